//--- hw/cia_flags.sv
// Behaviour
// RULE1: enable flag 0 blocks, 1 allows maskables
// RULE2: any acknowledge clears the enable flag
// RULE3: stack select 0 interrupt SP, 1 user SP
// RULE4: clear stack select on hw ack, swi 0-31
// RULE5: priority level is three bits, levels 0-7
// RULE6: accept only priority strictly above level
// RULE7: reserved bit written 0, reads undefined
// RULE8: accept needs enable and higher priority together
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`include "cia_map.svh"
`default_nettype none
module cia_flags #(
  parameter int LVL_W = 3
) (
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  // Wishbone slave
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [3:0]     wb_adr_i,
  input  wire logic [3:0]     wb_sel_i,
  input  wire logic [31:0]    wb_dat_i,
  output logic      [31:0]    wb_dat_o,
  output logic                wb_ack_o,
  // Interrupt controller
  input  wire cia_pkg::cia_req_t intReq,
  output logic                intAck,
  // Non-maskable or other hardware interrupt taken by the core
  input  wire logic           nmiAck,
  // Instruction sequencer
  input  wire cia_pkg::cia_swi_t swiEvt,
  // Stack logic
  output logic                userStackSel
);
  import cia_pkg::*;

  logic             enFlag_q;
  logic             stackSel_q;
  logic [LVL_W-1:0] level_q;
  logic             ackQ_q;
  logic             accept;
  logic             busReq;
  logic             flagsWr;

  // Both conditions judged in the same cycle, so no stale level can admit a request
  assign accept = intReq.valid && enFlag_q                          // [RULE1] [RULE8]
                  && (intReq.prio > level_q);                      // [RULE6] [RULE5]
  assign intAck = accept;

  // Selects the active stack pointer for the stack logic
  assign userStackSel = stackSel_q;                                // [RULE3]

  assign busReq  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign flagsWr = busReq && wb_we_i && wb_sel_i[0]
                   && (wb_adr_i == `CIA_FLAGS_OFS);

  // Enable flag: acknowledge wins over a software write in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enFlag_q <= `CIA_EN_RST;
    end else if (accept || nmiAck) begin
      enFlag_q <= 1'b0;                                            // [RULE2]
    end else if (flagsWr) begin
      enFlag_q <= wb_dat_i[`CIA_EN_BIT];                           // [RULE1]
    end
  end

  // Stack select: hardware ack or low software interrupt forces interrupt stack
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stackSel_q <= `CIA_SEL_RST;
    end else if (accept || nmiAck
                 || (swiEvt.exec && swiEvt.number <= `CIA_SWI_LOW_MAX)) begin
      stackSel_q <= 1'b0;                                          // [RULE4]
    end else if (flagsWr) begin
      stackSel_q <= wb_dat_i[`CIA_SEL_BIT];
    end
  end

  // Priority level, software written
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= `CIA_LVL_RST;
    end else if (flagsWr) begin
      level_q <= wb_dat_i[`CIA_LVL_MSB:`CIA_LVL_LSB];              // [RULE5]
    end
  end

  // Last-acknowledge status, sticky until the next bus read of status
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ackQ_q <= 1'b0;
    end else if (accept) begin
      ackQ_q <= 1'b1;
    end else if (busReq && !wb_we_i && wb_adr_i == `CIA_STATUS_OFS) begin
      ackQ_q <= 1'b0;
    end
  end

  // Bus answer one cycle after the request; unmapped reads return zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= busReq;
      wb_dat_o <= 32'h0;
      if (busReq && wb_adr_i == `CIA_FLAGS_OFS) begin
        wb_dat_o[`CIA_EN_BIT]               <= enFlag_q;
        wb_dat_o[`CIA_SEL_BIT]              <= stackSel_q;
        wb_dat_o[`CIA_RSV_BIT]              <= 1'b0;               // [RULE7]
        wb_dat_o[`CIA_LVL_MSB:`CIA_LVL_LSB] <= level_q;
      end else if (busReq && wb_adr_i == `CIA_STATUS_OFS) begin
        wb_dat_o[`CIA_ACC_BIT] <= ackQ_q || accept;
        wb_dat_o[`CIA_STK_BIT] <= stackSel_q;
      end
    end
  end
endmodule : cia_flags
`default_nettype wire

//--- include/cia_map.svh
`ifndef CIA_MAP_SVH
`define CIA_MAP_SVH
// Register byte offsets on the Wishbone slave
`define CIA_FLAGS_OFS      4'h0
`define CIA_STATUS_OFS     4'h4
// Field positions in the flags register
`define CIA_EN_BIT         0
`define CIA_SEL_BIT        1
`define CIA_RSV_BIT        2
`define CIA_LVL_LSB        4
`define CIA_LVL_MSB        6
// Field positions in the status register
`define CIA_ACC_BIT        0
`define CIA_STK_BIT        1
// Reset values
`define CIA_EN_RST         1'b0
`define CIA_SEL_RST        1'b0
`define CIA_LVL_RST        3'h0
// Software interrupt numbers that force the interrupt stack
`define CIA_SWI_LOW_MAX    6'h1F
`endif

//--- include/cia_pkg.sv
package cia_pkg;
  // Request offered by the interrupt controller
  typedef struct packed {
    logic       valid;
    logic [2:0] prio;
  } cia_req_t;
  // Software interrupt instruction event from the sequencer
  typedef struct packed {
    logic       exec;
    logic [5:0] number;
  } cia_swi_t;
endpackage : cia_pkg

//--- dv/cia_flags_checker.sv
`default_nettype none
module cia_flags_checker (
  input wire logic ref_clk, rst_n, wb_ack_o, wb_cyc_i, nmiAck, intAck, userStackSel,
  input wire cia_pkg::cia_req_t intReq,
  input wire cia_pkg::cia_swi_t swiEvt);
  timeunit 1ns; timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_en; intAck |=> !intAck; endproperty
  a_en: assert property (p_en) else $error("en");
  property p_as; intAck |=> !userStackSel; endproperty
  a_as: assert property (p_as) else $error("sp");
  property p_ns; nmiAck |=> !userStackSel; endproperty
  a_ns: assert property (p_ns) else $error("sp");
  property p_ss; swiEvt.exec && swiEvt.number < 6'h20 |=> !userStackSel; endproperty
  a_ss: assert property (p_ss) else $error("sp");
  property p_v; !intReq.valid |-> !intAck; endproperty
  a_v: assert property (p_v) else $error("rq");
  property p_l; intReq.prio == 3'h0 |-> !intAck; endproperty
  a_l: assert property (p_l) else $error("lv");
  // No bus write in between, so the cleared enable must still mask
  property p_m; intAck ##1 !wb_cyc_i |=> !intAck; endproperty
  a_m: assert property (p_m) else $error("mk");
  property p_u; $rose(userStackSel) |-> wb_ack_o; endproperty
  a_u: assert property (p_u) else $error("us");
endmodule : cia_flags_checker
bind cia_flags cia_flags_checker chk (.ref_clk, .rst_n, .wb_ack_o, .wb_cyc_i, .nmiAck,
  .intAck, .userStackSel, .intReq, .swiEvt);
`default_nettype wire

//--- dv/cia_irq_model.sv
`default_nettype none
module cia_irq_model (input wire logic ref_clk, rst_n, go, input wire logic [2:0] pr,
  output cia_pkg::cia_req_t rq);
  timeunit 1ns; timeprecision 1ns;
  // Pulsed request; idle lines flip so a stale priority never looks held
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) rq <= '0;
    else rq <= go ? {1'b1, pr} : {1'b0, ~rq.prio};
endmodule : cia_irq_model
`default_nettype wire

//--- dv/cia_flags_tb_top.sv
`default_nettype none
module cia_flags_tb_top;
  timeunit 1ns; timeprecision 1ns;
  logic c = 0, r = 0, cy = 0, w = 0, g = 0, nm = 0, en, x, k, a, u;
  logic [3:0] ad = 0; logic [31:0] d = 0, rd, q[$]; logic [2:0] p = 0, l; logic [5:0] n;
  cia_pkg::cia_req_t rq; cia_pkg::cia_swi_t s = '0;
  int num_errors = 0, comparisons = 0, seed = 27292, t = 0;
  always #50 c = ~c;
  cia_flags dut (.ref_clk(c), .rst_n(r), .wb_cyc_i(cy), .wb_stb_i(cy), .wb_we_i(w),
    .wb_adr_i(ad), .wb_sel_i(4'hF), .wb_dat_i(d), .wb_dat_o(rd), .wb_ack_o(a),
    .intReq(rq), .intAck(k), .nmiAck(nm), .swiEvt(s), .userStackSel(u));
  cia_irq_model irq (.ref_clk(c), .rst_n(r), .go(g), .pr(p), .rq(rq));
  task automatic chk(logic [31:0] v, e);
    comparisons++;
    if (v !== e) begin num_errors++; $display("ERROR %0t %h %h", $time, v, e); end
  endtask : chk
  // Classic cycle; a read notes its expected word first
  task automatic wb(logic we, logic [3:0] wa, logic [31:0] wd);
    if (!we) q.push_back(wd);
    cy <= 1; w <= we; ad <= wa; d <= wd;
    do @(posedge c); while (a !== 1'b1);
    cy <= 0; @(posedge c);
  endtask : wb
  task automatic wrap_up;
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Scoreboard and hang guard
  always @(posedge c) begin
    if (a === 1'b1 && w === 1'b0) chk(rd, q.pop_front());
    if (rq.valid === 1'b1) chk({31'h0, k}, q.pop_front());
    if (++t > 2000) begin num_errors++; wrap_up(); end
  end
  initial begin
    repeat (8) @(posedge c);
    r <= 1;
    wb(0, 4'h0, 32'h0);
    wb(0, 4'h8, 32'h0);
    for (int i = 0; i < 32; i++) begin
      l = 3'(i); en = !i[4]; n = 6'($random(seed)); x = en && n[2:0] > l;
      p <= n[2:0];
      wb(1, 4'h0, {25'h0, l, 2'h0, 1'b1, en}); // Reserved bit written 0
      q.push_back({31'h0, x}); g <= 1; @(posedge c); g <= 0;
      repeat (2) @(posedge c);
      wb(0, 4'h0, {25'h0, l, 2'h0, !x, en && !x});
      wb(0, 4'h4, {30'h0, !x, x}); // Status: stack select and sticky accept
    end
    for (int i = 0; i < 8; i++) begin
      n = i == 1 ? 6'h1F : i == 2 ? 6'h20 : 6'($random(seed));
      wb(1, 4'h0, 32'h2);
      if (i == 0) nm <= 1; else s <= {1'b1, n};
      @(posedge c); nm <= 0; s <= '0;
      wb(0, 4'h0, {30'h0, i > 0 && n > 6'h1F, 1'b0});
      chk({31'h0, u}, {31'h0, i > 0 && n > 6'h1F});
    end
    wrap_up();
  end
endmodule : cia_flags_tb_top
`default_nettype wire
